// ===== hdl/nsl_pkg.sv
// package: constants, states and register map of the node number switch loader
//
// Overview of operation
// - stored setup node number used unless hardware chosen or setup invalid
// - switch node number when hardware chosen or invalid
// - can: node is 1+8*code+axis-1, position1 msb
// - ethercat: second bank adds code msb, weight 128
// - can: protocol switch on selects vendor protocol
// - default node number 255 when nothing configured
// - canopen and node 255 hold lss inactive
// - ethercat node 255 writes alias zero
// - node addressing loads alias with node number
// - switches sampled once at power-up, later ignored
package nsl_pkg;

  // sizes
  localparam int unsigned NUM_AXES_DEF = 4;
  localparam int unsigned NODE_W       = 8;
  localparam int unsigned ALIAS_W      = 16;
  localparam int unsigned SEL_W        = 4;
  localparam int unsigned CODE_W       = 5;
  localparam int unsigned ADDR_W       = 8;
  localparam int unsigned DATA_W       = 32;

  // node number arithmetic
  localparam logic [7:0]  NODE_BASE    = 8'h01;
  localparam int unsigned NODE_SHIFT   = 3;      // eight node numbers per code step
  localparam logic [7:0]  NODE_DEFAULT = 8'hff;  // also the "unconfigured" marker
  localparam logic [7:0]  NODE_UNSET   = 8'h00;  // stored value outside 1..255
  localparam logic [15:0] ALIAS_NONE   = 16'h0000;

  // register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_STATUS    = 8'h04;
  localparam logic [7:0] REG_NODE0     = 8'h08;
  localparam logic [7:0] REG_ALIAS0    = 8'h18;
  localparam logic [7:0] REG_STEP      = 8'h04;

  // control register fields and reset values
  localparam int unsigned CTRL_ALIAS_BY_NODE_BIT = 0;
  localparam logic        CTRL_ALIAS_BY_NODE_RST = 1'b1;

  // status register fields
  localparam int unsigned STAT_DONE_BIT   = 0;
  localparam int unsigned STAT_VENDOR_BIT = 1;
  localparam int unsigned STAT_ECAT_BIT   = 2;
  localparam int unsigned STAT_HWSEL_BIT  = 3;
  localparam int unsigned STAT_LSS_LSB    = 4;

  // power-up sequence, one-hot
  typedef enum logic [3:0] {
    ST_CATCH  = 4'h1,
    ST_MAP    = 4'h2,
    ST_DERIVE = 4'h4,
    ST_RUN    = 4'h8
  } nsl_state_t;

endpackage

// ===== hdl/nsl_axis_node.sv
// module: node number of one axis, from stored setup or from the switch code
`timescale 1ns/1ps
module nsl_axis_node #(
  parameter int unsigned AXIS_IDX = 1
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  // latched configuration
  input  wire logic       load,
  input  wire logic [4:0] code,
  input  wire logic [7:0] setup_value,
  input  wire logic       setup_hw,
  input  wire logic       setup_valid,
  // result
  output logic [7:0]      node_q
);

  typedef struct packed {
    logic [7:0] node;
  } nsl_axis_t;

  nsl_axis_t st_q;
  nsl_axis_t st_d;
  logic [7:0] sw_node;

  // switch mapping: code steps by eight, axis picks the slot inside the step
  // can code mapping
  assign sw_node = nsl_pkg::NODE_BASE + (8'(code) << nsl_pkg::NODE_SHIFT)
                   + 8'(AXIS_IDX - 1);

  // choose source only on the load pulse, otherwise keep the value
  always_comb begin
    st_d = st_q;
    if (load) begin
      if (setup_hw || !setup_valid) begin
        st_d.node = sw_node;
      end else if (setup_value == nsl_pkg::NODE_UNSET) begin
        st_d.node = nsl_pkg::NODE_DEFAULT;
      end else begin
        st_d.node = setup_value;
      end
    end
  end

  // state register, default node number from reset on
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_q.node <= nsl_pkg::NODE_DEFAULT;
    end else begin
      st_q <= st_d;
    end
  end

  assign node_q = st_q.node;

endmodule

// ===== hdl/nsl_loader.sv
// module: power-up node number and protocol loader for a multi-axis drive
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps
module nsl_loader #(
  parameter int unsigned NUM_AXES = nsl_pkg::NUM_AXES_DEF
) (
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   resetn,
  // configuration switch pins, asynchronous
  input  wire logic [3:0]             node_select_switch,
  input  wire logic                   second_switch_bank,
  input  wire logic                   protocol_switch,
  input  wire logic                   ethercat_variant,
  // stored drive setup, same clock domain
  input  wire logic [NUM_AXES*8-1:0]  setup_node,
  input  wire logic [NUM_AXES-1:0]    setup_hw_select,
  input  wire logic                   setup_valid,
  // register port
  input  wire logic [7:0]             reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic [31:0]                 reg_rdata,
  // derived configuration
  output logic [NUM_AXES*8-1:0]       node_number,
  output logic [NUM_AXES*16-1:0]      station_alias,
  output logic [NUM_AXES-1:0]         lss_inactive,
  output logic                        vendor_can_protocol_mode,
  output logic                        config_done
);

  // synchroniser stages for the switch pins; no reset on purpose so that
  // the second stage already holds the pin levels when reset lets go
  typedef struct packed {
    logic [3:0] sel_a;
    logic [3:0] sel_b;
    logic       bank_a;
    logic       bank_b;
    logic       proto_a;
    logic       proto_b;
    logic       ecat_a;
    logic       ecat_b;
  } nsl_sync_t;

  // all remaining state of the loader
  typedef struct packed {
    nsl_pkg::nsl_state_t       fsm;
    logic [3:0]                sel;
    logic                      bank;
    logic                      proto;
    logic                      ecat;
    logic [NUM_AXES*8-1:0]     setup_val;
    logic [NUM_AXES-1:0]       setup_hw;
    logic                      setup_ok;
    logic                      load;
    logic                      alias_by_node;
    logic [NUM_AXES*16-1:0]    alias_out;
    logic [NUM_AXES-1:0]       lss;
    logic                      vendor;
    logic                      done;
    logic [31:0]               rdata;
  } nsl_state_s_t;

  nsl_sync_t          sy_q;
  nsl_state_s_t       st_q;
  nsl_state_s_t       st_d;
  logic [4:0]         code;
  logic [NUM_AXES*8-1:0] node_w;

  // two-stage synchronisers; the first stage feeds only the second
  always_ff @(posedge sys_clk) begin
    sy_q.sel_a   <= node_select_switch;
    sy_q.sel_b   <= sy_q.sel_a;
    sy_q.bank_a  <= second_switch_bank;
    sy_q.bank_b  <= sy_q.bank_a;
    sy_q.proto_a <= protocol_switch;
    sy_q.proto_b <= sy_q.proto_a;
    sy_q.ecat_a  <= ethercat_variant;
    sy_q.ecat_b  <= sy_q.ecat_a;
  end

  // switch code: position 1 is the msb of the four selection bits, the
  // second bank only counts on the ethercat variant
  // can code width
  assign code = {st_q.ecat & st_q.bank, st_q.sel};

  // one node number slice per axis
  genvar gi;
  generate
    for (gi = 0; gi < NUM_AXES; gi++) begin : g_axis
      nsl_axis_node #(
        .AXIS_IDX (gi + 1)
      ) u_axis (
        .sys_clk     (sys_clk),
        .resetn      (resetn),
        .load        (st_q.load),
        .code        (code),
        .setup_value (st_q.setup_val[gi*8 +: 8]),
        .setup_hw    (st_q.setup_hw[gi]),
        .setup_valid (st_q.setup_ok),
        .node_q      (node_w[gi*8 +: 8])
      );
    end
  endgenerate

  // next-state logic: power-up sequence, derived outputs and register port
  always_comb begin
    st_d       = st_q;
    st_d.load  = 1'b0;
    st_d.rdata = 32'h0000_0000;

    unique case (st_q.fsm)
      nsl_pkg::ST_CATCH: begin
        st_d.sel       = sy_q.sel_b;
        st_d.bank      = sy_q.bank_b;
        st_d.proto     = sy_q.proto_b;
        st_d.ecat      = sy_q.ecat_b;
        st_d.setup_val = setup_node;
        st_d.setup_hw  = setup_hw_select;
        st_d.setup_ok  = setup_valid;
        st_d.load      = 1'b1;
        st_d.fsm       = nsl_pkg::ST_MAP;
      end
      // axis slices register their node numbers in this cycle
      nsl_pkg::ST_MAP: begin
        st_d.fsm = nsl_pkg::ST_DERIVE;
      end
      // protocol choice, stays fixed until the next reset
      nsl_pkg::ST_DERIVE: begin
        st_d.vendor = ~st_q.ecat & st_q.proto;
        st_d.done   = 1'b1;
        st_d.fsm    = nsl_pkg::ST_RUN;
      end
      // later switch changes are never looked at again
      // ignore later changes
      nsl_pkg::ST_RUN: begin
        st_d.fsm = nsl_pkg::ST_RUN;
      end
    endcase

    // per-axis lss and alias, recomputed so the addressing mode may change
    for (int i = 0; i < NUM_AXES; i++) begin
      st_d.lss[i] = st_q.done & ~st_q.ecat & ~st_q.vendor
                    & (node_w[i*8 +: 8] == nsl_pkg::NODE_DEFAULT);
      if (!st_q.done || !st_q.ecat) begin
        st_d.alias_out[i*16 +: 16] = nsl_pkg::ALIAS_NONE;
      end else if (node_w[i*8 +: 8] == nsl_pkg::NODE_DEFAULT) begin
        st_d.alias_out[i*16 +: 16] = nsl_pkg::ALIAS_NONE;
      end else if (st_q.alias_by_node) begin
        st_d.alias_out[i*16 +: 16] = {8'h00, node_w[i*8 +: 8]};
      end else begin
        // position and other addressing modes leave the alias unused
        st_d.alias_out[i*16 +: 16] = nsl_pkg::ALIAS_NONE;
      end
    end

    // register writes: only the addressing mode is software controlled
    if (reg_wr && reg_addr == nsl_pkg::REG_CTRL) begin
      st_d.alias_by_node = reg_wdata[nsl_pkg::CTRL_ALIAS_BY_NODE_BIT];
    end

    // register reads: data stand in the next cycle only, unmapped read zero
    if (reg_rd) begin
      if (reg_addr == nsl_pkg::REG_CTRL) begin
        st_d.rdata[nsl_pkg::CTRL_ALIAS_BY_NODE_BIT] = st_q.alias_by_node;
      end else if (reg_addr == nsl_pkg::REG_STATUS) begin
        st_d.rdata[nsl_pkg::STAT_DONE_BIT]   = st_q.done;
        st_d.rdata[nsl_pkg::STAT_VENDOR_BIT] = st_q.vendor;
        st_d.rdata[nsl_pkg::STAT_ECAT_BIT]   = st_q.ecat;
        st_d.rdata[nsl_pkg::STAT_HWSEL_BIT]  = |st_q.setup_hw;
        st_d.rdata[nsl_pkg::STAT_LSS_LSB +: NUM_AXES] = st_q.lss;
      end
      for (int i = 0; i < NUM_AXES; i++) begin
        if (reg_addr == 8'(nsl_pkg::REG_NODE0 + 8'(i) * nsl_pkg::REG_STEP)) begin
          st_d.rdata[7:0] = node_w[i*8 +: 8];
        end
        if (reg_addr == 8'(nsl_pkg::REG_ALIAS0 + 8'(i) * nsl_pkg::REG_STEP)) begin
          st_d.rdata[15:0] = st_q.alias_out[i*16 +: 16];
        end
      end
    end
  end

  // state register; every control bit has a constant reset value
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_q.fsm           <= nsl_pkg::ST_CATCH;
      st_q.sel           <= 4'h0;
      st_q.bank          <= 1'b0;
      st_q.proto         <= 1'b0;
      st_q.ecat          <= 1'b0;
      st_q.setup_val     <= '0;
      st_q.setup_hw      <= '0;
      st_q.setup_ok      <= 1'b0;
      st_q.load          <= 1'b0;
      st_q.alias_by_node <= nsl_pkg::CTRL_ALIAS_BY_NODE_RST;
      st_q.alias_out     <= '0;
      st_q.lss           <= '0;
      st_q.vendor        <= 1'b0;
      st_q.done          <= 1'b0;
      st_q.rdata         <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flip-flops
  assign reg_rdata                = st_q.rdata;
  assign node_number              = node_w;
  assign station_alias            = st_q.alias_out;
  assign lss_inactive             = st_q.lss;
  assign vendor_can_protocol_mode = st_q.vendor;
  assign config_done              = st_q.done;

endmodule

// ===== verif/nsl_switch_model.sv
// partner model: configuration switch pins and stored drive setup
`timescale 1ns/1ps
module nsl_switch_model #(
  parameter int unsigned W = 8
) (
  // clock and control
  input  wire logic         sys_clk,
  input  wire logic         scramble,
  // wanted configuration and resulting pins
  input  wire logic [W-1:0] cfg_bits,
  output logic [W-1:0]      pin_bits
);
  logic flip_q = 1'h0;

  // toggle every cycle so any resampling after power-up would show
  always @(posedge sys_clk) begin
    flip_q <= scramble & ~flip_q;
  end

  // pins move after power-up; the variant strap never does
  assign pin_bits = cfg_bits ^ {1'h0, {(W-1){flip_q}}};
endmodule

// ===== verif/nsl_loader_sva.sv
// checker: port-level assertions of the node number loader
`timescale 1ns/1ps
module nsl_loader_sva #(
  parameter int unsigned NUM_AXES = 4
) (
  input wire logic                   sys_clk,
  input wire logic                   resetn,
  input wire logic                   ethercat_variant,
  input wire logic [NUM_AXES*8-1:0]  node_number,
  input wire logic [NUM_AXES*16-1:0] station_alias,
  input wire logic [NUM_AXES-1:0]    lss_inactive,
  input wire logic                   vendor_can_protocol_mode,
  input wire logic                   config_done
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  // done is registered at the third edge, so it is first sampled high at the fourth
  a_done_timing: assert property (
      $rose(resetn) |-> !config_done ##1 !config_done ##1 !config_done ##1 config_done)
    else $error("config_done not on fourth edge after reset");
  a_done_holds: assert property (config_done |=> config_done)
    else $error("config_done dropped");
  a_node_frozen: assert property (config_done |=> $stable(node_number))
    else $error("node number changed after power-up");
  a_node_range: assert property (config_done |-> node_number[7:0] != 8'h00)
    else $error("node number zero");
  a_vendor_can: assert property (
      config_done && ethercat_variant |-> !vendor_can_protocol_mode)
    else $error("vendor mode on ethercat variant");
  a_lss_match: assert property (
      $past(config_done) |-> lss_inactive[0] ==
      (!ethercat_variant && !vendor_can_protocol_mode && node_number[7:0] == 8'hff))
    else $error("lss inactive mismatch");
  a_alias_zero: assert property (
      $past(config_done) && node_number[7:0] == 8'hff |-> station_alias[15:0] == 16'h0000)
    else $error("alias not zero for node 255");
  a_alias_node: assert property (
      $past(config_done) && station_alias[15:0] != 16'h0000
      |-> station_alias[15:0] == {8'h00, node_number[7:0]} && ethercat_variant)
    else $error("alias differs from node number");
endmodule

bind nsl_loader nsl_loader_sva #(.NUM_AXES(NUM_AXES)) i_sva (
  .sys_clk(sys_clk),
  .resetn(resetn),
  .ethercat_variant(ethercat_variant),
  .node_number(node_number),
  .station_alias(station_alias),
  .lss_inactive(lss_inactive),
  .vendor_can_protocol_mode(vendor_can_protocol_mode),
  .config_done(config_done)
);

// ===== verif/tb.sv
// testbench: power-up node number and protocol loading scenarios
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb;
  localparam int unsigned NA = 4;
  typedef struct packed {
    logic          ecat;
    logic [3:0]    sel;
    logic          bank;
    logic          proto;
    logic          valid;
    logic [NA-1:0] hw;
    logic [NA*8-1:0] setup;
  } nsl_tb_cfg_t;
  logic            sys_clk = 1'h0;
  logic            resetn = 1'h0;
  logic            scramble = 1'h0;
  logic [7:0]      reg_addr = 8'h00;
  logic [31:0]     reg_wdata = 32'h00000000;
  logic            reg_wr = 1'h0;
  logic            reg_rd = 1'h0;
  logic [31:0]     reg_rdata;
  logic [NA*8-1:0] node_number;
  logic [NA*16-1:0] station_alias;
  logic [NA-1:0]   lss_inactive;
  logic            vendor_can_protocol_mode;
  logic            config_done;
  int              err_total = 0;
  int              n_tests = 0;
  nsl_tb_cfg_t     cfg = '0;
  nsl_tb_cfg_t     pin;

  // 40 MHz system clock
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  nsl_switch_model #(.W($bits(nsl_tb_cfg_t))) i_sw (.sys_clk(sys_clk), .scramble(scramble),
    .cfg_bits(cfg), .pin_bits(pin));
  nsl_loader #(.NUM_AXES(NA)) i_dut (.sys_clk(sys_clk), .resetn(resetn),
    .node_select_switch(pin.sel), .second_switch_bank(pin.bank), .protocol_switch(pin.proto),
    .ethercat_variant(pin.ecat), .setup_node(pin.setup), .setup_hw_select(pin.hw),
    .setup_valid(pin.valid), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .node_number(node_number),
    .station_alias(station_alias), .lss_inactive(lss_inactive),
    .vendor_can_protocol_mode(vendor_can_protocol_mode), .config_done(config_done));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // pins settle during the five reset cycles, well before release
  task automatic power_up(input nsl_tb_cfg_t c);
    @(posedge sys_clk);
    resetn <= 1'h0;
    cfg <= c;
    repeat (5) @(posedge sys_clk);
    resetn <= 1'h1;
    repeat (6) @(posedge sys_clk);
    #1;
  endtask

  task automatic check_cfg(input nsl_tb_cfg_t c, input logic abn);
    logic [7:0] code;
    logic [7:0] n;
    code = {3'h0, c.ecat & c.bank, c.sel};
    for (int i = 0; i < NA; i++) begin
      n = c.setup[8*i+:8] == 8'h00 ? 8'hff : c.setup[8*i+:8];
      n = (c.hw[i] | !c.valid) ? 8'h01 + (code << 3) + 8'(i) : n;
      `CHK("node", n, node_number[8*i+:8])
      `CHK("alias", (c.ecat && abn && n != 8'hff) ? {8'h00, n} : 16'h0000,
        station_alias[16*i+:16])
      `CHK("lss", !c.ecat && !c.proto && n == 8'hff, lss_inactive[i])
    end
    `CHK("vendor", !c.ecat & c.proto, vendor_can_protocol_mode)
    `CHK("done", 1'h1, config_done)
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
  endtask

  // read data stands only in the cycle after the read edge
  task automatic reg_check(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    #1;
    `CHK("rdata", e, reg_rdata)
  endtask

  task automatic t_default();
    power_up('{1'h0, 4'h5, 1'h1, 1'h0, 1'h1, 4'h0, 32'h00000000});
    check_cfg(cfg, 1'h1);
    reg_check(nsl_pkg::REG_STATUS, 32'h000000f1);
  endtask

  // switches and setup keep moving after power-up
  task automatic t_frozen();
    power_up('{1'h0, 4'h3, 1'h0, 1'h1, 1'h1, 4'h0, 32'hfe800201});
    scramble <= 1'h1;
    repeat (20) @(posedge sys_clk);
    #1;
    check_cfg(cfg ^ '0, 1'h1);
    reg_check(nsl_pkg::REG_STATUS, 32'h00000003);
    scramble <= 1'h0;
  endtask

  task automatic t_can_codes();
    for (int k = 0; k < 16; k++) begin
      power_up('{1'h0, 4'(k), 1'h1, k[0], 1'h1, 4'hf, 32'h11111111});
      check_cfg(cfg, 1'h1);
    end
    power_up('{1'h0, 4'ha, 1'h0, 1'h0, 1'h0, 4'h0, 32'h22222222});
    check_cfg(cfg, 1'h1);
  endtask

  task automatic t_ecat();
    for (int k = 0; k < 4; k++) begin
      power_up('{1'h1, k[0] ? 4'hf : 4'h0, k[1], 1'h1, 1'h1, 4'hf, 32'h00000000});
      check_cfg(cfg, 1'h1);
    end
    reg_check(nsl_pkg::REG_CTRL, 32'h00000001);
    reg_check(nsl_pkg::REG_ALIAS0, 32'h000000f9);
    reg_check(nsl_pkg::REG_STATUS, 32'h0000000d);
    reg_write(nsl_pkg::REG_CTRL, 32'h00000000);
    repeat (2) @(posedge sys_clk);
    #1;
    check_cfg(cfg, 1'h0);
    reg_check(nsl_pkg::REG_NODE0 + nsl_pkg::REG_STEP, 32'h000000fa);
    reg_check(8'hfc, 32'h00000000);
    power_up('{1'h1, 4'h7, 1'h1, 1'h0, 1'h1, 4'h0, 32'h00000000});
    check_cfg(cfg, 1'h1);
  endtask

  // a hang still ends through the closing task
  initial begin
    #200us;
    err_total++;
    report_and_stop();
  end

  initial begin
    t_default();
    t_frozen();
    t_can_codes();
    t_ecat();
    report_and_stop();
  end
endmodule
